// file: design/dscg_pkg.sv
// Package with register map, field positions and reset values of the deep-sleep clock gate.
package dscg_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] DSCG_OFF_GATE      = 12'h120; // deep_sleep_clock_gate_0
	localparam logic [11:0] DSCG_OFF_RUN_GATE  = 12'h100; // run_clock_gate_0
	localparam logic [11:0] DSCG_OFF_SLP_GATE  = 12'h110; // sleep_clock_gate_0
	localparam logic [11:0] DSCG_OFF_CTRL      = 12'h130; // auto_clock_gating_select and mode
	localparam logic [11:0] DSCG_OFF_IRQ_STAT  = 12'h140;
	localparam logic [11:0] DSCG_OFF_IRQ_EN    = 12'h144;
	localparam logic [11:0] DSCG_OFF_IRQ_CLR   = 12'h148;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int DSCG_BIT_CAN  = 24;
	localparam int DSCG_BIT_ADC  = 16;
	localparam int DSCG_BIT_WDOG = 3;
	localparam int DSCG_BIT_RSV1 = 6;

	// Mask of writable gating bits and reset value.
	localparam logic [31:0] DSCG_WR_MASK   = 32'h0101_0008;
	localparam logic [31:0] DSCG_GATE_RST  = 32'h0000_0040;
	localparam logic [31:0] DSCG_RSV_ONES  = 32'h0000_0040;
	localparam logic [31:0] DSCG_ZERO      = 32'h0000_0000;

	// Interrupt status bits.
	localparam int DSCG_IRQ_FAULT  = 0;
	localparam int DSCG_IRQ_CHANGE = 1;
	localparam int DSCG_IRQ_W      = 2;

	// Power modes.
	typedef enum logic [1:0] {
		DSCG_MODE_RUN   = 2'b00,
		DSCG_MODE_SLEEP = 2'b01,
		DSCG_MODE_DEEP  = 2'b10
	} dscg_mode_e;

endpackage

// file: design/dscg_top.sv
// Deep-sleep clock gating control with APB slave, mode selection and fault detection.
`timescale 1ns/1ps

// Functional notes
// [RULE1] Gating bit is the peripheral clock enable.
// [RULE2] Access to gated-off peripheral gets bus fault.
// [RULE3] Gating bits reset cleared, all unclocked.
// [RULE4] Register resets to 0x00000040, bit6 reads one.
// [RULE5] Run, sleep, deep gates chosen by mode.
// [RULE6] Sleep/deep gates used only with auto select.
// [RULE7] Software enables peripherals it needs.
// [RULE8] Reserved bits read-only, no clocking effect.
// [RULE9] Software preserves reserved bits on update.
// [RULE10] Writable bits: 24 CAN, 16 ADC, 3 watchdog.
module dscg_top
	import dscg_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        can_access,
	input  wire logic        adc_access,
	input  wire logic        wdog_access,
	output logic             can_unit_clock_gate,
	output logic             adc_clock_gate,
	output logic             watchdog_clock_gate,
	output logic             can_fault,
	output logic             adc_fault,
	output logic             wdog_fault,
	output logic [1:0]       power_mode,
	output logic             irq
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [31:0] deep_sleep_clock_gate_0;
	logic [31:0] run_clock_gate_0;
	logic [31:0] sleep_clock_gate_0;
	logic        auto_clock_gating_select;
	logic [1:0]  mode;
	logic [DSCG_IRQ_W-1:0] irq_stat;
	logic [DSCG_IRQ_W-1:0] irq_en;
	logic        acc_phase;
	// Applied enables and bus faults, one flip-flop per peripheral; the
	// nets gather them so that the selection and the ports see one vector.
	wire  [2:0]  gate_q;
	wire  [2:0]  fault_q;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Answer one cycle after the access phase starts, giving registered read data.
	wire         bus_req   = psel & penable & ~acc_phase;
	wire         wr_en     = bus_req & pwrite & clk_en;
	wire         hit_gate  = (paddr == DSCG_OFF_GATE);
	wire         hit_run   = (paddr == DSCG_OFF_RUN_GATE);
	wire         hit_slp   = (paddr == DSCG_OFF_SLP_GATE);
	wire         hit_ctrl  = (paddr == DSCG_OFF_CTRL);
	wire         hit_stat  = (paddr == DSCG_OFF_IRQ_STAT);
	wire         hit_en    = (paddr == DSCG_OFF_IRQ_EN);
	wire         hit_clr   = (paddr == DSCG_OFF_IRQ_CLR);
	wire         hit_any   = hit_gate | hit_run | hit_slp | hit_ctrl | hit_stat | hit_en | hit_clr;
	// Status is read-only and clear is write-only; wrong direction is an error.
	wire         bad_dir   = (hit_stat & pwrite) | (hit_clr & ~pwrite);
	wire         bus_err   = ~hit_any | bad_dir;

	// Byte-lane mask built from the strobes.
	wire [31:0]  lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	// [RULE8] reserved stay read-only
	wire [31:0]  wmask     = lane_mask & DSCG_WR_MASK;

	// Merge write data into a gating register, keeping reserved bits.
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
					      input logic [31:0] m);
		merge = (cur & ~m) | (wd & m);
	endfunction

	wire [31:0]  next_gate  = merge(deep_sleep_clock_gate_0, pwdata, wmask);
	wire [31:0]  next_run   = merge(run_clock_gate_0, pwdata, wmask);
	wire [31:0]  next_slp   = merge(sleep_clock_gate_0, pwdata, wmask);

	// ------------------------------------------------------------------
	// Gate selection
	// ------------------------------------------------------------------
	// [RULE5] pick gate by mode
	// [RULE6] auto select required
	wire         use_deep   = auto_clock_gating_select & (mode == DSCG_MODE_DEEP);
	wire         use_slp    = auto_clock_gating_select & (mode == DSCG_MODE_SLEEP);
	wire [31:0]  active     = use_deep ? deep_sleep_clock_gate_0 :
				  use_slp  ? sleep_clock_gate_0 : run_clock_gate_0;
	// [RULE10] writable bit positions
	wire [2:0]   act_en     = {active[DSCG_BIT_CAN], active[DSCG_BIT_ADC], active[DSCG_BIT_WDOG]};
	wire [2:0]   acc_req    = {can_access, adc_access, wdog_access};

	// [RULE2] fault on gated access
	// Judged against the applied enable, the one the peripheral clock follows.
	wire [2:0]   next_fault = acc_req & ~gate_q;
	wire         gate_diff  = (act_en != {can_unit_clock_gate, adc_clock_gate,
				     watchdog_clock_gate});

	// Events: any fault, and any change of the applied enables.
	wire [DSCG_IRQ_W-1:0] evt = {gate_diff, |next_fault};
	wire [DSCG_IRQ_W-1:0] clr = (wr_en & hit_clr) ? pwdata[DSCG_IRQ_W-1:0] : '0;

	// Read multiplexer.
	wire [31:0]  rd_mux =
		hit_gate ? (deep_sleep_clock_gate_0 | DSCG_RSV_ONES) :
		hit_run  ? (run_clock_gate_0 | DSCG_RSV_ONES) :
		hit_slp  ? (sleep_clock_gate_0 | DSCG_RSV_ONES) :
		hit_ctrl ? {29'h0000_0000, mode, auto_clock_gating_select} :
		hit_stat ? {30'h0000_0000, irq_stat} :
		hit_en   ? {30'h0000_0000, irq_en} : DSCG_ZERO;

	// ------------------------------------------------------------------
	// APB response
	// ------------------------------------------------------------------
	// Answer qualifiers, worked out once so each flip-flop below stays a plain copy.
	wire         next_pslverr = bus_req & bus_err;
	wire         rd_ok        = bus_req & ~pwrite & ~bus_err;
	wire [31:0]  next_prdata  = rd_ok ? rd_mux : DSCG_ZERO;

	// Access-phase marker: blocks a second answer while the master still
	// holds the request in the cycle in which pready is high.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_phase <= 1'b0;
		end else if (clk_en) begin
			acc_phase <= bus_req;
		end
	end

	// A single wait state keeps the answer registered like every other output.
	// The cost is one extra cycle per access, which software never notices.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= bus_req;
			pslverr <= next_pslverr;
		end
	end

	// Read data is forced to zero outside an answer, so a stale word never
	// leaks onto the bus when the master looks in the wrong cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= DSCG_ZERO;
		end else if (clk_en) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------------
	// Gating registers
	// ------------------------------------------------------------------
	// Write strobes per gating register; clk_en is already folded into wr_en,
	// so a frozen block ignores the bus as well.
	wire         wr_gate    = wr_en & hit_gate;
	wire         wr_run     = wr_en & hit_run;
	wire         wr_slp     = wr_en & hit_slp;

	// Deep-sleep gate, the register this block exists for.
	// [RULE3] reset cleared
	// [RULE4] reset value 0x40
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			deep_sleep_clock_gate_0 <= DSCG_GATE_RST;
		end else if (wr_gate) begin
			deep_sleep_clock_gate_0 <= next_gate;
		end
	end

	// Run-mode gate; it stays in force whenever auto selection is off.
	// [RULE3] reset cleared
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_clock_gate_0 <= DSCG_GATE_RST;
		end else if (wr_run) begin
			run_clock_gate_0 <= next_run;
		end
	end

	// Sleep-mode gate, same layout and reset as the other two.
	// [RULE3] reset cleared
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sleep_clock_gate_0 <= DSCG_GATE_RST;
		end else if (wr_slp) begin
			sleep_clock_gate_0 <= next_slp;
		end
	end

	// Both small registers live in byte lane 0, so only that strobe matters.
	wire         wr_ctrl    = wr_en & hit_ctrl & pstrb[0];
	wire         wr_irq_en  = wr_en & hit_en & pstrb[0];

	// Control register: auto select bit and current power mode.
	// Mode code 3 is kept as written and simply selects the run gate.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			auto_clock_gating_select <= 1'b0;
			mode                     <= DSCG_MODE_RUN;
		end else if (wr_ctrl) begin
			auto_clock_gating_select <= pwdata[0];
			mode                     <= pwdata[2:1];
		end
	end

	// Interrupt enable register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_en <= '0;
		end else if (wr_irq_en) begin
			irq_en <= pwdata[DSCG_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Outputs and interrupt
	// ------------------------------------------------------------------
	// Per-peripheral flip-flops. Index 2 is CAN, 1 is the ADC, 0 the watchdog.
	// The fault looks at the applied enable, not the one just selected, so it
	// always agrees with the clock that the peripheral really gets.
	for (genvar ch = 0; ch < 3; ch = ch + 1) begin : g_ch
		logic en_q;
		logic flt_q;

		// [RULE1] enables drive clocks
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				en_q <= 1'b0;
			end else if (clk_en) begin
				en_q <= act_en[ch];
			end
		end

		// [RULE2] fault on gated access
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				flt_q <= 1'b0;
			end else if (clk_en) begin
				flt_q <= next_fault[ch];
			end
		end

		assign gate_q[ch]  = en_q;
		assign fault_q[ch] = flt_q;
	end

	// Outputs are plain copies of the per-peripheral flip-flops.
	assign can_unit_clock_gate = gate_q[2];
	assign adc_clock_gate      = gate_q[1];
	assign watchdog_clock_gate = gate_q[0];
	assign can_fault           = fault_q[2];
	assign adc_fault           = fault_q[1];
	assign wdog_fault          = fault_q[0];

	// Power mode as seen by the rest of the clock controller.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			power_mode <= DSCG_MODE_RUN;
		end else if (clk_en) begin
			power_mode <= mode;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	// A new event wins over a clear in the same cycle so no event is lost;
	// software simply sees the bit again on its next read.
	wire [DSCG_IRQ_W-1:0] next_irq_stat = (irq_stat & ~clr) | evt;
	wire                  next_irq      = |(next_irq_stat & irq_en);

	// Sticky status bits.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_stat <= '0;
		end else if (clk_en) begin
			irq_stat <= next_irq_stat;
		end
	end

	// The line is registered from the next status, so it rises together
	// with the status bit rather than one cycle behind it.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= next_irq;
		end
	end

endmodule // dscg_top

// file: test/dscg_asserts.sv
// Checker for the deep-sleep clock gate ports.
`timescale 1ns/1ps
module dscg_chk (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        can_access,
	input wire logic        adc_access,
	input wire logic        wdog_access,
	input wire logic        can_unit_clock_gate,
	input wire logic        adc_clock_gate,
	input wire logic        watchdog_clock_gate,
	input wire logic        can_fault,
	input wire logic        adc_fault,
	input wire logic        wdog_fault
);
	// All checks share one clock; reset masks them.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_can_fault; clk_en |=> can_fault == $past(can_access && !can_unit_clock_gate); endproperty
	a_can_fault: assert property (p_can_fault) else $error("can fault wrong");
	property p_adc_fault; clk_en |=> adc_fault == $past(adc_access && !adc_clock_gate); endproperty
	a_adc_fault: assert property (p_adc_fault) else $error("adc fault wrong");
	property p_wd_fault; clk_en |=> wdog_fault == $past(wdog_access && !watchdog_clock_gate); endproperty
	a_wd_fault: assert property (p_wd_fault) else $error("watchdog fault wrong");
	property p_rst_gate; $fell(rst) |-> !(can_unit_clock_gate || adc_clock_gate || watchdog_clock_gate); endproperty
	a_rst_gate: assert property (p_rst_gate) else $error("gate on after reset");
	property p_freeze; !clk_en |=> $stable({can_unit_clock_gate, adc_clock_gate, watchdog_clock_gate}); endproperty
	a_freeze: assert property (p_freeze) else $error("gate moved while frozen");
	property p_answer; clk_en && psel && penable && !pready |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("late bus answer");
	property p_pulse; pready && clk_en |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_rdzero; !pready |-> prdata == 32'h0; endproperty
	a_rdzero: assert property (p_rdzero) else $error("read data outside answer");
endmodule // dscg_chk
bind dscg_top dscg_chk u_chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .can_access(can_access),
	.adc_access(adc_access), .wdog_access(wdog_access), .can_unit_clock_gate(can_unit_clock_gate),
	.adc_clock_gate(adc_clock_gate), .watchdog_clock_gate(watchdog_clock_gate),
	.can_fault(can_fault), .adc_fault(adc_fault), .wdog_fault(wdog_fault));

// file: test/tb_top.sv
// Self-checking bench for the deep-sleep clock gate.
`timescale 1ns/1ps
module tb_top
	import dscg_pkg::*;
;
	logic clk_sys = 0, rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, r;
	logic [2:0] acc = 3'h0;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [2:0] gate, fault;
	wire [1:0] power_mode;
	int miscompares = 0, num_checks = 0;
	// Free-running system clock.
	always #4 clk_sys = ~clk_sys;
	dscg_top DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .can_access(acc[2]), .adc_access(acc[1]),
		.wdog_access(acc[0]), .can_unit_clock_gate(gate[2]), .adc_clock_gate(gate[1]),
		.watchdog_clock_gate(gate[0]), .can_fault(fault[2]), .adc_fault(fault[1]),
		.wdog_fault(fault[0]), .power_mode(power_mode), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; a dead slave is caught by the watchdog, not here.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		chk("answer", {30'h0, pready, pslverr}, {30'h0, 1'b1, e});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 1'b0);
		chk("read", r, x);
	endtask
	// Outputs settle a cycle after the register, so two edges are allowed.
	task automatic gchk(input logic [2:0] x);
		repeat (2) @(posedge clk_sys);
		chk("gates", {29'h0, gate}, {29'h0, x});
	endtask
	task automatic touch(input logic [2:0] v, input logic [2:0] x);
		@(posedge clk_sys) acc <= v;
		@(posedge clk_sys) acc <= 3'h0;
		@(posedge clk_sys);
		chk("fault", {29'h0, fault}, {29'h0, x});
	endtask
	task automatic close_out;
		if (miscompares == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd(DSCG_OFF_GATE, DSCG_GATE_RST);
		gchk(3'b000);
		touch(3'b111, 3'b111);
		apb(1'b1, DSCG_OFF_GATE, 32'hFFFF_FFFF, 1'b0);
		rd(DSCG_OFF_GATE, 32'h0101_0048);
		gchk(3'b000);
		apb(1'b1, DSCG_OFF_CTRL, 32'h5, 1'b0);
		gchk(3'b111);
		chk("mode", {30'h0, power_mode}, 32'h2);
		apb(1'b1, DSCG_OFF_GATE, 32'h0001_0040, 1'b0);
		gchk(3'b010);
		touch(3'b111, 3'b101);
		apb(1'b1, DSCG_OFF_CTRL, 32'h3, 1'b0);
		gchk(3'b000);
		apb(1'b1, DSCG_OFF_RUN_GATE, 32'h8, 1'b0);
		apb(1'b1, DSCG_OFF_CTRL, 32'h4, 1'b0);
		gchk(3'b001);
		clk_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		clk_en <= 1'b1;
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'b1, DSCG_OFF_IRQ_EN, 32'h1, 1'b0);
		rd(DSCG_OFF_IRQ_STAT, 32'h3);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b1, DSCG_OFF_IRQ_CLR, 32'h3, 1'b0);
		rd(DSCG_OFF_IRQ_STAT, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'b1, DSCG_OFF_IRQ_STAT, 32'h1, 1'b1);
		apb(1'b0, 12'h1FC, 32'h0, 1'b1);
		close_out;
	end
	// Watchdog well beyond the fewer than one hundred cycles the sequence needs.
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		close_out;
	end
endmodule // tb_top
